// File: hdl/swc_pkg.sv
/*
 * Constants and types for the suspend, wake-up clocking and wake-up timer block.
 * Assumes a 25 MHz system clock and a classic Wishbone register bus.
 */
package swc_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int SWC_CLK_PERIOD_NS  = 40;
	localparam int SWC_T_INT_START_NS = 2000;
	localparam int SWC_INT_START_CYC  = (SWC_T_INT_START_NS / SWC_CLK_PERIOD_NS < 1) ? 1 :
		SWC_T_INT_START_NS / SWC_CLK_PERIOD_NS;
	localparam int SWC_T_INT_DELAY_NS = 8000;
	localparam int SWC_INT_DELAY_CYC  =
		(SWC_T_INT_DELAY_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;
	localparam int SWC_T_EXT_SHORT_NS = 128000;
	localparam int SWC_EXT_SHORT_CYC  =
		(SWC_T_EXT_SHORT_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;
	localparam int SWC_T_EXT_LONG_NS  = 4000000;
	localparam int SWC_EXT_LONG_CYC   =
		(SWC_T_EXT_LONG_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;
	localparam int SWC_DLY_W          = 17;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] SWC_ADDR_CLKCFG  = 8'h00;
	localparam logic [7:0] SWC_ADDR_CTRL    = 8'h04;
	localparam logic [7:0] SWC_ADDR_STATE   = 8'h08;
	localparam logic [7:0] SWC_ADDR_INTSTAT = 8'h0C;
	localparam logic [7:0] SWC_ADDR_INTMASK = 8'h10;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int SWC_CFG_EXTOSC_BIT = 0;
	localparam int SWC_CFG_EXTDLY_BIT = 3;
	localparam int SWC_CFG_ADJ_LSB    = 4;
	localparam int SWC_ADJ_W          = 3;
	localparam int SWC_CTRL_RUN_BIT   = 0;
	localparam int SWC_CTRL_WAKIE_BIT = 1;
	localparam int SWC_CTRL_SUSP_BIT  = 3;
	localparam int SWC_INT_WAKE_BIT   = 0;
	localparam int SWC_INT_RESUME_BIT = 1;
	localparam int SWC_INT_W          = 2;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [2:0] SWC_ADJ_RST     = 3'h0;
	localparam logic       SWC_RUN_RST     = 1'h1;
	localparam logic       SWC_CPU_RUN_RST = 1'h1;
	localparam logic       SWC_INT_CLK_RST = 1'h1;
	localparam logic [1:0] SWC_INT_RST     = 2'h0;

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SWC_RUN,
		SWC_SUSPEND,
		SWC_INT_DELAY,
		SWC_EXT_START,
		SWC_EXT_DELAY
	} swc_state_type;

endpackage

// File: hdl/swc_wake_ctrl.sv
/*
 * Suspend entry, wake-up clock sequencing and the periodic wake-up timer,
 * with its register file on a classic Wishbone slave and one interrupt line.
 * Assumes wakeEvent, extOscStable and wakeTick come from outside the clock
 * domain, and wdtReset and instrRetired are single-cycle pulses on clk.
 */
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module swc_wake_ctrl #(
	parameter int EXT_LONG_CYC    = swc_pkg::SWC_EXT_LONG_CYC,
	parameter int WAKE_BASE_TICKS = 16,
	parameter int CNT_W           = 16
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        wakeEvent,
	input  wire logic        extOscStable,
	input  wire logic        wakeTick,
	input  wire logic        wdtReset,
	input  wire logic        instrRetired,
	output logic             intOut,
	output logic             cpuRun,
	output logic             intClkOn,
	output logic             extOscOn,
	output logic             clkSrcExt,
	output logic             suspended,
	output logic             irqHold
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		swc_pkg::swc_state_type           state;
		logic                             cfgExtOsc;
		logic                             cfgExtDelay;
		logic [swc_pkg::SWC_ADJ_W-1:0]    cfgAdj;
		logic                             ctrlRun;
		logic                             ctrlWakeIe;
		logic                             clkExt;
		logic [swc_pkg::SWC_DLY_W-1:0]    dlyCnt;
		logic [CNT_W-1:0]                 wakeCnt;
		logic [swc_pkg::SWC_INT_W-1:0]    intStat;
		logic [swc_pkg::SWC_INT_W-1:0]    intMask;
		logic                             ack;
		logic [31:0]                      rdata;
		logic                             intOut;
		logic                             cpuRun;
		logic                             intClkOn;
		logic                             extOscOn;
		logic                             suspended;
		logic                             irqHold;
		logic [2:0]                       syncWake;
		logic [2:0]                       syncStable;
		logic [2:0]                       syncTick;
		logic                             wakeF;
		logic                             stableF;
		logic                             tickF;
	} swc_regs_type;

	swc_regs_type state_reg;
	swc_regs_type state_next;

	// Wake period in ticks of the low-power time base.
	// The counter must be wide enough for the longest setting of 128 base periods.
	function automatic logic [CNT_W-1:0] swcPeriod(input logic [swc_pkg::SWC_ADJ_W-1:0] adj);
		swcPeriod = CNT_W'(WAKE_BASE_TICKS) << adj;
	endfunction

	// Three-stage sampling; a change counts once the last two stages agree.
	function automatic logic swcFilter(input logic [2:0] s, input logic prev);
		swcFilter = (s[1] == s[2]) ? s[2] : prev;
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic                          busReq;
		logic                          wrCfg;
		logic                          wrCtrl;
		logic                          wrStat;
		logic                          wrMask;
		logic                          tickEdge;
		logic                          wakeReq;
		logic [swc_pkg::SWC_INT_W-1:0] setInt;
		logic [swc_pkg::SWC_INT_W-1:0] clrInt;
		busReq   = 1'b0;
		wrCfg    = 1'b0;
		wrCtrl   = 1'b0;
		wrStat   = 1'b0;
		wrMask   = 1'b0;
		tickEdge = 1'b0;
		wakeReq  = 1'b0;
		setInt   = '0;
		clrInt   = '0;
		state_next = state_reg;

		// ------------------------------------------------------------------
		// Pin sampling
		// ------------------------------------------------------------------
		// A filtered copy only moves once the last two stages agree, so a slow
		// or ringing edge on a pin gives one event and not two.
		state_next.syncWake   = {state_reg.syncWake[1:0], wakeEvent};
		state_next.syncStable = {state_reg.syncStable[1:0], extOscStable};
		state_next.syncTick   = {state_reg.syncTick[1:0], wakeTick};
		state_next.wakeF      = swcFilter(state_reg.syncWake, state_reg.wakeF);
		state_next.stableF    = swcFilter(state_reg.syncStable, state_reg.stableF);
		state_next.tickF      = swcFilter(state_reg.syncTick, state_reg.tickF);
		tickEdge = state_next.tickF & ~state_reg.tickF;

		// ------------------------------------------------------------------
		// Bus slave
		// ------------------------------------------------------------------
		// One wait state; ack drops the cycle after it is given, which keeps a
		// request still held in the ack cycle from being taken a second time.
		busReq = wb_cyc_i & wb_stb_i & ~state_reg.ack;
		state_next.ack = busReq;
		if (busReq & wb_we_i & wb_sel_i[0]) begin
			wrCfg  = (wb_adr_i == swc_pkg::SWC_ADDR_CLKCFG);
			wrCtrl = (wb_adr_i == swc_pkg::SWC_ADDR_CTRL);
			wrStat = (wb_adr_i == swc_pkg::SWC_ADDR_INTSTAT);
			wrMask = (wb_adr_i == swc_pkg::SWC_ADDR_INTMASK);
		end
		state_next.rdata = '0;
		if (busReq & ~wb_we_i) begin
			unique case (wb_adr_i)
				swc_pkg::SWC_ADDR_CLKCFG: begin
					state_next.rdata[swc_pkg::SWC_CFG_EXTOSC_BIT] = state_reg.cfgExtOsc;
					state_next.rdata[swc_pkg::SWC_CFG_EXTDLY_BIT] = state_reg.cfgExtDelay;
					state_next.rdata[swc_pkg::SWC_CFG_ADJ_LSB +: swc_pkg::SWC_ADJ_W] =
						state_reg.cfgAdj;
				end
				swc_pkg::SWC_ADDR_CTRL: begin
					state_next.rdata[swc_pkg::SWC_CTRL_RUN_BIT]   = state_reg.ctrlRun;
					state_next.rdata[swc_pkg::SWC_CTRL_WAKIE_BIT] = state_reg.ctrlWakeIe;
				end
				swc_pkg::SWC_ADDR_STATE: begin
					state_next.rdata[4:0] = {state_reg.irqHold, state_reg.intClkOn,
						state_reg.extOscOn, state_reg.clkExt, state_reg.cpuRun};
				end
				swc_pkg::SWC_ADDR_INTSTAT: begin
					state_next.rdata[swc_pkg::SWC_INT_W-1:0] = state_reg.intStat;
				end
				swc_pkg::SWC_ADDR_INTMASK: begin
					state_next.rdata[swc_pkg::SWC_INT_W-1:0] = state_reg.intMask;
				end
				default: begin
					state_next.rdata = '0;
				end
			endcase
		end

		// ------------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------------
		if (wrCfg) begin
			state_next.cfgExtOsc   = wb_dat_i[swc_pkg::SWC_CFG_EXTOSC_BIT];
			state_next.cfgExtDelay = wb_dat_i[swc_pkg::SWC_CFG_EXTDLY_BIT];
			state_next.cfgAdj      = wb_dat_i[swc_pkg::SWC_CFG_ADJ_LSB +: swc_pkg::SWC_ADJ_W];
		end
		if (wrCtrl) begin
			state_next.ctrlRun    = wb_dat_i[swc_pkg::SWC_CTRL_RUN_BIT];
			state_next.ctrlWakeIe = wb_dat_i[swc_pkg::SWC_CTRL_WAKIE_BIT];
		end
		if (wrMask) begin
			state_next.intMask = wb_dat_i[swc_pkg::SWC_INT_W-1:0];
		end
		if (wrStat) begin
			clrInt = wb_dat_i[swc_pkg::SWC_INT_W-1:0];
		end

		// Watchdog reset drops the external enable and the adjust field only.
		if (wdtReset) begin
			state_next.cfgExtOsc = 1'b0;
			state_next.cfgAdj    = swc_pkg::SWC_ADJ_RST;
		end

		// ------------------------------------------------------------------
		// Wake-up timer
		// ------------------------------------------------------------------
		// It counts in every state, suspend included; only its enable stops it.
		if (!state_reg.ctrlWakeIe) begin
			state_next.wakeCnt = '0;
		end else if (tickEdge) begin
			if (state_reg.wakeCnt + CNT_W'(1) >= swcPeriod(state_reg.cfgAdj)) begin
				state_next.wakeCnt = '0;
				setInt[swc_pkg::SWC_INT_WAKE_BIT] = 1'b1;
			end else begin
				state_next.wakeCnt = state_reg.wakeCnt + CNT_W'(1);
			end
		end

		// ------------------------------------------------------------------
		// Suspend and wake sequencer
		// ------------------------------------------------------------------
		// Any pending enabled interrupt or the wake pin resumes, given the run bit.
		wakeReq = (state_reg.wakeF | (|(state_reg.intStat & state_reg.intMask)))
			& state_reg.ctrlRun;

		unique case (state_reg.state)
			swc_pkg::SWC_RUN: begin
				if (wrCtrl & wb_dat_i[swc_pkg::SWC_CTRL_SUSP_BIT]) begin
					state_next.state     = swc_pkg::SWC_SUSPEND;
					state_next.clkExt    = state_reg.cfgExtOsc;
					state_next.cpuRun    = 1'b0;
					state_next.intClkOn  = 1'b0;
					state_next.extOscOn  = 1'b0;
					state_next.suspended = 1'b1;
				end else if (state_reg.cfgExtOsc & ~state_reg.clkExt) begin
					// The core and the internal clock halt while the oscillator
					// starts; clearing the enable later does not switch back.
					state_next.state    = swc_pkg::SWC_EXT_START;
					state_next.cpuRun   = 1'b0;
					state_next.intClkOn = 1'b0;
					state_next.extOscOn = 1'b1;
				end
			end
			swc_pkg::SWC_SUSPEND: begin
				if (wakeReq) begin
					state_next.suspended = 1'b0;
					// The clock source was latched at suspend entry, so a later
					// change of the enable bit cannot change how this wake runs.
					if (state_reg.clkExt) begin
						state_next.state    = swc_pkg::SWC_EXT_START;
						state_next.extOscOn = 1'b1;
					end else begin
						state_next.state    = swc_pkg::SWC_INT_DELAY;
						state_next.intClkOn = 1'b1;
						state_next.dlyCnt   =
							swc_pkg::SWC_DLY_W'(swc_pkg::SWC_INT_DELAY_CYC - 1);
					end
				end
			end
			swc_pkg::SWC_INT_DELAY: begin
				// The counter was loaded one short, so reaching zero ends the full delay.
				if (state_reg.dlyCnt == '0) begin
					state_next.state   = swc_pkg::SWC_RUN;
					state_next.cpuRun  = 1'b1;
					state_next.irqHold = 1'b1;
					setInt[swc_pkg::SWC_INT_RESUME_BIT] = 1'b1;
				end else begin
					state_next.dlyCnt = state_reg.dlyCnt - swc_pkg::SWC_DLY_W'(1);
				end
			end
			swc_pkg::SWC_EXT_START: begin
				// The start-up delay is only counted once the filtered stable flag is seen.
				if (state_reg.stableF) begin
					state_next.state  = swc_pkg::SWC_EXT_DELAY;
					state_next.dlyCnt = state_reg.cfgExtDelay ?
						swc_pkg::SWC_DLY_W'(EXT_LONG_CYC - 1) :
						swc_pkg::SWC_DLY_W'(swc_pkg::SWC_EXT_SHORT_CYC - 1);
				end
			end
			swc_pkg::SWC_EXT_DELAY: begin
				if (state_reg.dlyCnt == '0) begin
					state_next.state   = swc_pkg::SWC_RUN;
					state_next.clkExt  = 1'b1;
					state_next.cpuRun  = 1'b1;
					state_next.irqHold = 1'b1;
					setInt[swc_pkg::SWC_INT_RESUME_BIT] = 1'b1;
				end else begin
					state_next.dlyCnt = state_reg.dlyCnt - swc_pkg::SWC_DLY_W'(1);
				end
			end
			default: begin
				state_next.state = swc_pkg::SWC_RUN;
			end
		endcase

		// ------------------------------------------------------------------
		// Interrupt hold and status
		// ------------------------------------------------------------------
		// Interrupt servicing stays held until the first instruction has retired.
		if (state_reg.irqHold & instrRetired) begin
			state_next.irqHold = 1'b0;
		end

		// A set in the same cycle as a write-one clear wins.
		state_next.intStat = (state_reg.intStat & ~clrInt) | setInt;
		state_next.intOut  = |(state_next.intStat & state_next.intMask);
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Reset clears every field, then gives the run bit, the core run flag and the internal clock their awake values.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg             <= '0;
			state_reg.state       <= swc_pkg::SWC_RUN;
			state_reg.cfgAdj      <= swc_pkg::SWC_ADJ_RST;
			state_reg.ctrlRun     <= swc_pkg::SWC_RUN_RST;
			state_reg.intStat     <= swc_pkg::SWC_INT_RST;
			state_reg.intMask     <= swc_pkg::SWC_INT_RST;
			state_reg.cpuRun      <= swc_pkg::SWC_CPU_RUN_RST;
			state_reg.intClkOn    <= swc_pkg::SWC_INT_CLK_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Every output is a field of the registered state, never a decode.
	assign wb_dat_o  = state_reg.rdata;
	assign wb_ack_o  = state_reg.ack;
	assign intOut    = state_reg.intOut;
	assign cpuRun    = state_reg.cpuRun;
	assign intClkOn  = state_reg.intClkOn;
	assign extOscOn  = state_reg.extOscOn;
	assign clkSrcExt = state_reg.clkExt;
	assign suspended = state_reg.suspended;
	assign irqHold   = state_reg.irqHold;

endmodule // swc_wake_ctrl

// File: verif/swc_wake_monitor.sv
/*
 * Port checker for the suspend, wake clocking and wake timer block.
 * Assumes the block's clk and rst_b and the hand-over timing of its bus.
 */
`timescale 1ns/10ps
module swc_wake_monitor (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        extOscStable,
	input wire logic        wdtReset,
	input wire logic        instrRetired,
	input wire logic        cpuRun,
	input wire logic        intClkOn,
	input wire logic        extOscOn,
	input wire logic        clkSrcExt,
	input wire logic        suspended,
	input wire logic        irqHold
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic suspWr;
	assign suspWr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == swc_pkg::SWC_ADDR_CTRL && wb_dat_i[swc_pkg::SWC_CTRL_SUSP_BIT];

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	susp_entry_a: assert property (suspWr && cpuRun && !suspended |=> suspended && !cpuRun)
		else $error("suspend not entered");
	int_resume_a: assert property ($rose(intClkOn) && !clkSrcExt |-> ##199 !cpuRun ##1 cpuRun)
		else $error("internal resume delay wrong");
	osc_off_a: assert property (suspended && !clkSrcExt |-> !extOscOn)
		else $error("oscillator on in internal suspend");
	ext_stable_a: assert property (extOscOn && !cpuRun && !extOscStable |=> !cpuRun)
		else $error("resumed before oscillator stable");
	ext_delay_a: assert property ($rose(extOscOn) |-> !cpuRun [*8])
		else $error("external resume too early");
	resume_hold_a: assert property ($rose(cpuRun) |-> irqHold)
		else $error("interrupts not held on resume");
	hold_free_a: assert property (irqHold && instrRetired |=> !irqHold)
		else $error("hold not released");
	src_keep_a: assert property (wdtReset && clkSrcExt && !suspended |=> clkSrcExt)
		else $error("clock source changed by watchdog");
endmodule // swc_wake_monitor

bind swc_wake_ctrl swc_wake_monitor u_mon (
	.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .extOscStable(extOscStable), .wdtReset(wdtReset),
	.instrRetired(instrRetired), .cpuRun(cpuRun), .intClkOn(intClkOn), .extOscOn(extOscOn),
	.clkSrcExt(clkSrcExt), .suspended(suspended), .irqHold(irqHold)
);

// File: verif/tb.sv
/*
 * Self-checking bench for the suspend, wake clocking and wake timer block.
 * Assumes one tick per base wake period and a short long-delay count.
 */
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] aCfg  = swc_pkg::SWC_ADDR_CLKCFG;
	localparam logic [7:0] aCtrl = swc_pkg::SWC_ADDR_CTRL;
	localparam logic [7:0] aStat = swc_pkg::SWC_ADDR_INTSTAT;
	logic        clk;
	logic        rst_b;
	logic        cyc;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] datW;
	logic [31:0] datR;
	logic        ack;
	logic        wakeEvent;
	logic        extOscStable;
	logic        wakeTick;
	logic        wdtReset;
	logic        instrRetired;
	logic        intOut;
	logic [5:0]  fl;
	logic [31:0] rd;
	int          errTotal;
	int          checked;
	int          n;

	swc_wake_ctrl #(.EXT_LONG_CYC(20), .WAKE_BASE_TICKS(1), .CNT_W(16)) u_dut (
		.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
		.wakeEvent(wakeEvent), .extOscStable(extOscStable), .wakeTick(wakeTick),
		.wdtReset(wdtReset), .instrRetired(instrRetired), .intOut(intOut), .cpuRun(fl[0]),
		.intClkOn(fl[1]), .extOscOn(fl[2]), .clkSrcExt(fl[3]), .suspended(fl[4]),
		.irqHold(fl[5])
	);

	task automatic endSim();
		if (errTotal == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Cyc and stb share one driver, so they rise and fall together.
	task automatic busOp(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rd = datR;
		cyc <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			errTotal++;
			endSim();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busOp(1'b1, a, d);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		busOp(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic waitFl(input int i, input int lim);
		n = 0;
		while (fl[i] !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (fl[i] !== 1'b1) begin
			errTotal++;
			endSim();
		end
	endtask

	task automatic tick();
		@(posedge clk);
		wakeTick <= 1'b1;
		repeat (4) @(posedge clk);
		wakeTick <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		rst_b = 1'b0;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		datW = 32'h0;
		wakeEvent = 1'b0;
		extOscStable = 1'b0;
		wakeTick = 1'b0;
		wdtReset = 1'b0;
		instrRetired = 1'b0;
		errTotal = 0;
		checked = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rdChk(aCfg, 32'h00);
		rdChk(aCtrl, 32'h01);
		rdChk(8'h14, 32'h00);
		for (int k = 0; k < 8; k++) begin
			wr(aCfg, 32'(k) << 4);
			wr(aCtrl, 32'h01);
			wr(aCtrl, 32'h03);
			repeat ((1 << k) - 1) tick();
			rdChk(aStat, 32'h00);
			tick();
			rdChk(aStat, 32'h01);
			wr(aStat, 32'h01);
		end
		wr(aCfg, 32'h10);
		tick();
		wr(aCtrl, 32'h01);
		tick();
		rdChk(aStat, 32'h00);
		wr(aCtrl, 32'h03);
		tick();
		rdChk(aStat, 32'h00);
		tick();
		wr(swc_pkg::SWC_ADDR_INTMASK, 32'h01);
		rdChk(aStat, 32'h01);
		chk(intOut, 1'b1);
		wr(aCtrl, 32'h01);
		wr(aStat, 32'h01);
		rdChk(aStat, 32'h00);
		chk(intOut, 1'b0);
		wr(aCtrl, 32'h08);
		@(posedge clk);
		chk(fl[4:0], 5'h10);
		wakeEvent <= 1'b1;
		repeat (20) @(posedge clk);
		chk(fl[4:0], 5'h10);
		wakeEvent <= 1'b0;
		repeat (10) @(posedge clk);
		wr(aCtrl, 32'h01);
		wakeEvent <= 1'b1;
		waitFl(1, 50);
		waitFl(0, 300);
		chk(n, 200);
		wakeEvent <= 1'b0;
		chk(fl[5], 1'b1);
		rdChk(aStat, 32'h02);
		wr(aStat, 32'h02);
		instrRetired <= 1'b1;
		@(posedge clk);
		instrRetired <= 1'b0;
		@(posedge clk);
		chk(fl[5], 1'b0);
		wr(aCfg, 32'h71);
		repeat (50) @(posedge clk);
		chk(fl[3:0], 4'h4);
		extOscStable <= 1'b1;
		waitFl(0, 3400);
		chk(n >= 3200, 1'b1);
		chk(fl[3], 1'b1);
		instrRetired <= 1'b1;
		@(posedge clk);
		instrRetired <= 1'b0;
		wdtReset <= 1'b1;
		@(posedge clk);
		wdtReset <= 1'b0;
		rdChk(aCfg, 32'h00);
		chk(fl[3], 1'b1);
		wr(aCfg, 32'h09);
		wr(aCtrl, 32'h09);
		extOscStable <= 1'b0;
		repeat (10) @(posedge clk);
		chk(fl[4:0], 5'h18);
		wakeEvent <= 1'b1;
		waitFl(2, 50);
		extOscStable <= 1'b1;
		waitFl(0, 400);
		chk(n >= 20, 1'b1);
		chk(fl[3], 1'b1);
		endSim();
	end
endmodule // tb
